// ---- verilog/tmr_defs.svh ----
// Register offsets, field positions, reset values for the capture/match timer
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define OFS_FLAGS 8'h00
`define OFS_CTL 8'h04
`define OFS_TC 8'h08
`define OFS_PR 8'h0C
`define OFS_PC 8'h10
`define OFS_MCTL 8'h14
`define OFS_MR0 8'h18
`define OFS_CCTL 8'h28
`define OFS_CR0 8'h2C
`define OFS_EXT 8'h3C
`define OFS_CNT 8'h40
`define CTL_EN 0
`define CTL_RST 1
`define MC_INT 0
`define MC_RST 1
`define MC_STOP 2
`define MC_STRIDE 3
`define CC_RISE 0
`define CC_FALL 1
`define CC_INT 2
`define CC_AND 3
`define CC_STRIDE 4
`define EXT_ACT_LSB 4
`define FLAG_CAP_LSB 4
`define RST_WORD 32'h0000_0000
`endif

// ---- verilog/tmr_pkg.sv ----
// Types shared by the capture/match timer
package tmr_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
    typedef enum logic [1:0] {MODE_TIMER, MODE_RISE, MODE_FALL, MODE_BOTH} count_mode_t;
    typedef enum logic [1:0] {ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE} ext_act_t;
endpackage

// ---- verilog/cap_edge.sv ----
// Capture pin combiner and edge detector for one channel
`timescale 1ns/1ps
`default_nettype none
module cap_edge #(
    parameter int PINS = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [PINS-1:0] pins,
    input wire logic use_and,
    output logic rise,
    output logic fall
);
    logic level;
    logic prev;
    logic next_prev;

    // Several pins feed one channel, merged by OR or AND
    always_comb
    begin
        level = use_and ? (&pins) : (|pins);
        next_prev = level;
        rise = level & ~prev;
        fall = ~level & prev;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prev <= 1'b0;
        else
            prev <= next_prev;
    end
endmodule
`default_nettype wire

// ---- verilog/tmr_capture_match.sv ----
// 32-bit timer/counter with prescaler, four match and four capture channels
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_capture_match #(
    parameter int CAP_PINS = 2,
    parameter int MAT_PINS = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire tmr_pkg::bus_req_t bus,
    output logic [31:0] rdata,
    input wire logic [4*CAP_PINS-1:0] cap_pins,
    output logic [4*MAT_PINS-1:0] match_pins,
    output logic int_pending
);
    import tmr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] flags, next_flags;
    logic [1:0] ctl, next_ctl;
    logic [31:0] tc, next_tc;
    logic [31:0] pr, next_pr;
    logic [31:0] pc, next_pc;
    logic [11:0] mctl, next_mctl;
    logic [15:0] cctl, next_cctl;
    logic [11:0] ext, next_ext;
    logic [3:0] cnt, next_cnt;
    logic [31:0] mr [4];
    logic [31:0] next_mr [4];
    logic [31:0] cr [4];
    logic [31:0] next_cr [4];
    logic [31:0] next_rdata;
    logic next_int;
    logic [3:0] rise, fall, cap_ev, hit;
    logic run, tick, step, do_reset, do_stop;
    count_mode_t mode;

    // ------------------------------------------------------------
    // Capture inputs
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_cap
            cap_edge #(.PINS(CAP_PINS)) u_edge (
                .clk(clk),
                .rst(rst),
                .pins(cap_pins[g*CAP_PINS +: CAP_PINS]),
                .use_and(cctl[g*`CC_STRIDE + `CC_AND]),
                .rise(rise[g]),
                .fall(fall[g])
            );
            // Every channel captures, the count source included
            assign cap_ev[g] = (rise[g] & cctl[g*`CC_STRIDE + `CC_RISE])
                             | (fall[g] & cctl[g*`CC_STRIDE + `CC_FALL]);
            assign hit[g] = step && (tc == mr[g]);
            // Each match state drives a group of pins
            assign match_pins[g*MAT_PINS +: MAT_PINS] = {MAT_PINS{ext[g]}};
        end
    endgenerate

    // ------------------------------------------------------------
    // Count source and prescaler
    // ------------------------------------------------------------
    // Edges need one clk sample per level, hence the outside limits
    always_comb
    begin
        mode = count_mode_t'(cnt[1:0]);
        run = ctl[`CTL_EN] && !ctl[`CTL_RST];
        case (mode)
            MODE_TIMER: tick = 1'b1;
            MODE_RISE: tick = rise[cnt[3:2]];
            MODE_FALL: tick = fall[cnt[3:2]];
            MODE_BOTH: tick = rise[cnt[3:2]] | fall[cnt[3:2]];
            default: tick = 1'b0;
        endcase
        step = run && tick && (pc == pr);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_flags = flags;
        next_ctl = ctl;
        next_tc = tc;
        next_pr = pr;
        next_pc = pc;
        next_mctl = mctl;
        next_cctl = cctl;
        next_ext = ext;
        next_cnt = cnt;
        next_mr = mr;
        next_cr = cr;
        next_rdata = `RST_WORD;
        do_reset = 1'b0;
        do_stop = 1'b0;

        // Clear first so that a same-cycle event still sets its flag
        if (bus.wr && bus.addr == `OFS_FLAGS)
            next_flags = flags & ~bus.wdata[7:0];

        for (int i = 0; i < 4; i++)
        begin
            if (hit[i])
            begin
                if (mctl[i*`MC_STRIDE + `MC_INT])
                    next_flags[i] = 1'b1;
                if (mctl[i*`MC_STRIDE + `MC_RST])
                    do_reset = 1'b1;
                if (mctl[i*`MC_STRIDE + `MC_STOP])
                    do_stop = 1'b1;
                case (ext_act_t'(ext[`EXT_ACT_LSB + 2*i +: 2]))
                    ACT_LOW: next_ext[i] = 1'b0;
                    ACT_HIGH: next_ext[i] = 1'b1;
                    ACT_TOGGLE: next_ext[i] = ~ext[i];
                    default: next_ext[i] = ext[i];
                endcase
            end
            if (cap_ev[i])
            begin
                next_cr[i] = tc;
                if (cctl[i*`CC_STRIDE + `CC_INT])
                    next_flags[`FLAG_CAP_LSB + i] = 1'b1;
            end
        end

        if (ctl[`CTL_RST])
        begin
            next_pc = `RST_WORD;
            next_tc = `RST_WORD;
        end
        else if (run && tick)
        begin
            if (pc == pr)
            begin
                next_pc = `RST_WORD;
                if (do_reset)
                    next_tc = `RST_WORD;
                else if (!do_stop)
                    next_tc = tc + 32'h0000_0001;
            end
            else
                next_pc = pc + 32'h0000_0001;
        end
        if (do_stop)
            next_ctl[`CTL_EN] = 1'b0;

        // Software writes land after the hardware updates
        if (bus.wr)
        begin
            case (bus.addr)
                `OFS_CTL: next_ctl = bus.wdata[1:0];
                `OFS_TC: next_tc = bus.wdata;
                `OFS_PR: next_pr = bus.wdata;
                `OFS_MCTL: next_mctl = bus.wdata[11:0];
                `OFS_CCTL: next_cctl = bus.wdata[15:0];
                `OFS_EXT: next_ext = bus.wdata[11:0];
                `OFS_CNT: next_cnt = bus.wdata[3:0];
                default: next_cnt = next_cnt;
            endcase
            for (int i = 0; i < 4; i++)
                if (bus.addr == 8'(`OFS_MR0 + 4*i))
                    next_mr[i] = bus.wdata;
        end

        if (bus.rd)
        begin
            case (bus.addr)
                `OFS_FLAGS: next_rdata = {24'h00_0000, flags};
                `OFS_CTL: next_rdata = {30'h0000_0000, ctl};
                `OFS_TC: next_rdata = tc;
                `OFS_PR: next_rdata = pr;
                `OFS_PC: next_rdata = pc;
                `OFS_MCTL: next_rdata = {20'h0_0000, mctl};
                `OFS_CCTL: next_rdata = {16'h0000, cctl};
                `OFS_EXT: next_rdata = {20'h0_0000, ext};
                `OFS_CNT: next_rdata = {28'h000_0000, cnt};
                default: next_rdata = `RST_WORD;
            endcase
            for (int i = 0; i < 4; i++)
            begin
                if (bus.addr == 8'(`OFS_MR0 + 4*i))
                    next_rdata = mr[i];
                if (bus.addr == 8'(`OFS_CR0 + 4*i))
                    next_rdata = cr[i];
            end
        end
        next_int = |next_flags;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flags <= 8'h00;
            ctl <= 2'h0;
            tc <= `RST_WORD;
            pr <= `RST_WORD;
            pc <= `RST_WORD;
            mctl <= 12'h000;
            cctl <= 16'h0000;
            ext <= 12'h000;
            cnt <= 4'h0;
            mr <= '{default: `RST_WORD};
            cr <= '{default: `RST_WORD};
            rdata <= `RST_WORD;
            int_pending <= 1'b0;
        end
        else
        begin
            flags <= next_flags;
            ctl <= next_ctl;
            tc <= next_tc;
            pr <= next_pr;
            pc <= next_pc;
            mctl <= next_mctl;
            cctl <= next_cctl;
            ext <= next_ext;
            cnt <= next_cnt;
            mr <= next_mr;
            cr <= next_cr;
            rdata <= next_rdata;
            int_pending <= next_int;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic tc_wr, ctl_wr;
    assign tc_wr = bus.wr && bus.addr == `OFS_TC;
    assign ctl_wr = bus.wr && bus.addr == `OFS_CTL;

    sequence s_stop_hit;
        hit[0] && mctl[`MC_STOP] && !mctl[`MC_RST] && !do_reset && !tc_wr && !ctl_wr;
    endsequence
    sequence s_halted;
        !ctl[`CTL_EN] && tc == $past(tc);
    endsequence

    chk_prescale_wrap: assert property (step |=> pc == 32'h0000_0000)
        else $error("prescaler did not wrap at terminal value");
    chk_count_step: assert property (step && hit == 4'h0 && !tc_wr
        |=> tc == $past(tc) + 32'h0000_0001)
        else $error("counter did not advance on prescaler wrap");
    chk_timer_mode: assert property (mode == MODE_TIMER && run && pc != pr
        |=> pc == $past(pc) + 32'h0000_0001)
        else $error("prescaler missed a clock in timer mode");
    chk_ext_idle: assert property (mode != MODE_TIMER && run && !tick && !tc_wr
        |=> $stable(tc) && $stable(pc))
        else $error("counter moved without a selected input edge");
    chk_match_continue: assert property (hit[1] && mctl[5:3] == 3'h0 && !tc_wr
        && !do_reset && !do_stop |=> tc == $past(tc) + 32'h0000_0001)
        else $error("plain match disturbed the count");
    chk_match_stop: assert property (s_stop_hit |=> s_halted)
        else $error("stop on match did not halt the counter");
    chk_match_flag: assert property (hit[0] && mctl[`MC_INT] |=> flags[0])
        else $error("match did not raise its flag");
    chk_match_reset: assert property (hit[1] && mctl[`MC_STRIDE + `MC_RST] && !tc_wr
        |=> tc == 32'h0000_0000)
        else $error("reset on match did not clear the counter");
    chk_hold_clear: assert property (ctl[`CTL_RST] && !tc_wr
        |=> tc == 32'h0000_0000 && pc == 32'h0000_0000)
        else $error("hold in reset did not clear the counters");
    chk_capture_load: assert property (cap_ev[3] |=> cr[3] == $past(tc))
        else $error("capture did not latch the count");
    chk_cap_flag: assert property (cap_ev[1] && cctl[`CC_STRIDE + `CC_INT]
        |=> flags[`FLAG_CAP_LSB + 1])
        else $error("capture did not raise its flag");
    chk_ext_toggle: assert property (hit[0] && ext[5:4] == 2'h3 && !bus.wr
        |=> ext[0] != $past(ext[0]) && match_pins[0] == ext[0])
        else $error("match output did not toggle");
    chk_flag_sticky: assert property (flags[5]
        && !(bus.wr && bus.addr == `OFS_FLAGS && bus.wdata[5]) |=> flags[5])
        else $error("capture flag dropped without a clear");
endmodule
`default_nettype wire

// ---- dv/cap_source.sv ----
// Behavioural outside sources that drive the timer's capture pins
`timescale 1ns/1ps
`default_nettype none
module cap_source #(
    parameter int CAP_PINS = 2
) (
    input wire logic clk,
    output logic [4*CAP_PINS-1:0] cap_pins
);
    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    initial cap_pins = '0;
    task automatic set_pin(input int idx, input logic val);
        @(posedge clk);
        cap_pins[idx] <= val;
    endtask
    task automatic clear();
        @(posedge clk);
        cap_pins <= '0;
    endtask
    // Two cycles high and two low, so the count clock is a quarter of clk, or half of clk when both edges count
    task automatic pulses(input int idx, input int n);
        repeat (n)
        begin
            set_pin(idx, 1'b1);
            @(posedge clk);
            set_pin(idx, 1'b0);
            @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking testbench for the capture/match timer
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module testbench;
    import tmr_pkg::*;
    logic clk;
    logic rst;
    bus_req_t bus;
    logic [31:0] rdata;
    logic [7:0] cap_pins;
    logic [7:0] match_pins;
    logic int_pending;
    int err_count;
    int n_checks;
    int toggles;
    logic prev;
    logic [31:0] d;
    tmr_capture_match #(.CAP_PINS(2), .MAT_PINS(2)) u_tmr_capture_match (
        .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .cap_pins(cap_pins),
        .match_pins(match_pins), .int_pending(int_pending));
    cap_source #(.CAP_PINS(2)) u_cap_source (.clk(clk), .cap_pins(cap_pins));
    // ----------------------------------------
    // Bus and checking tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(name, v, exp);
    endtask
    task automatic pin(input int idx, input logic val);
        u_cap_source.set_pin(idx, val);
        repeat (3) @(posedge clk);
    endtask
    task automatic reset_dut();
        u_cap_source.clear();
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Tests take about 450 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial
    begin
        rst = 1'b1;
        bus = '0;
        err_count = 0;
        n_checks = 0;
        reset_dut();
        rchk("ctl", `OFS_CTL, 0);
        rchk("tc", `OFS_TC, 0);
        rchk("flags", `OFS_FLAGS, 0);
        check("match_pins", 32'(match_pins), 0);
        wr(8'h80, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h80, 0);
        $display("test reset done");
        wr(`OFS_PR, 2);
        wr(`OFS_MR0, 5);
        wr(`OFS_MCTL, 5);
        wr(`OFS_CTL, 1);
        repeat (40) @(posedge clk);
        rchk("tc stop", `OFS_TC, 5);
        rchk("ctl stop", `OFS_CTL, 0);
        rchk("flag stop", `OFS_FLAGS, 1);
        check("int set", 32'(int_pending), 1);
        wr(`OFS_FLAGS, 1);
        rchk("flag clr", `OFS_FLAGS, 0);
        check("int clr", 32'(int_pending), 0);
        $display("test stop done");
        for (int a = 0; a < 4; a++)
        begin
            wr(`OFS_CTL, 2);
            wr(`OFS_EXT, (a << 4) | 32'(a != 2));
            wr(`OFS_MR0, 2);
            wr(`OFS_MCTL, 1);
            wr(`OFS_CTL, 1);
            repeat (20) @(posedge clk);
            rchk("ext", `OFS_EXT, (a << 4) | 32'(a == 0 || a == 2));
            check("pins", 32'(match_pins[1:0]), (a == 0 || a == 2) ? 3 : 0);
            rd(`OFS_TC, d);
            check("tc runs", 32'(d > 2), 1);
        end
        $display("test actions done");
        reset_dut();
        wr(`OFS_MR0 + 8'h04, 3);
        wr(`OFS_MCTL, 32'h0000_0018);
        wr(`OFS_EXT, 32'h0000_00C0);
        wr(`OFS_CTL, 1);
        for (int i = 0; i < 8; i++)
        begin
            rd(`OFS_TC, d);
            check("tc wrap", 32'(d <= 3), 1);
        end
        toggles = 0;
        prev = match_pins[2];
        repeat (40)
        begin
            @(posedge clk);
            #1;
            toggles += int'(match_pins[2] !== prev);
            prev = match_pins[2];
        end
        check("toggles", 32'(toggles), 10);
        check("bcast", 32'(match_pins[3] === match_pins[2]), 1);
        rchk("flag rst", `OFS_FLAGS, 2);
        $display("test reset match done");
        reset_dut();
        wr(`OFS_CCTL, 32'h0000_6950);
        wr(`OFS_TC, 32'h1234_5678);
        pin(3, 1'b1);
        rchk("cr1 or", `OFS_CR0 + 8'h04, 32'h1234_5678);
        pin(4, 1'b1);
        rchk("cr2 half", `OFS_CR0 + 8'h08, 0);
        wr(`OFS_TC, 32'h0000_00AB);
        pin(5, 1'b1);
        rchk("cr2 and", `OFS_CR0 + 8'h08, 32'h0000_00AB);
        pin(6, 1'b1);
        rchk("cr3 rise", `OFS_CR0 + 8'h0C, 0);
        pin(6, 1'b0);
        rchk("cr3 fall", `OFS_CR0 + 8'h0C, 32'h0000_00AB);
        rchk("cap flags", `OFS_FLAGS, 32'h0000_00A0);
        check("cap int", 32'(int_pending), 1);
        $display("test capture done");
        reset_dut();
        wr(`OFS_CNT, 1);
        wr(`OFS_CCTL, 32'h0000_0010);
        wr(`OFS_CTL, 1);
        u_cap_source.pulses(0, 5);
        repeat (4) @(posedge clk);
        rchk("ext count", `OFS_TC, 5);
        pin(2, 1'b1);
        rchk("other cap", `OFS_CR0 + 8'h04, 5);
        rchk("one source", `OFS_TC, 5);
        wr(`OFS_CTL, 2);
        wr(`OFS_CNT, 32'h0000_000F);
        wr(`OFS_CTL, 1);
        u_cap_source.pulses(6, 3);
        repeat (4) @(posedge clk);
        rchk("both edges", `OFS_TC, 6);
        wr(`OFS_CTL, 2);
        wr(`OFS_CNT, 32'h0000_000A);
        wr(`OFS_CTL, 1);
        u_cap_source.pulses(4, 2);
        repeat (4) @(posedge clk);
        rchk("fall edges", `OFS_TC, 2);
        $display("test external done");
        final_report();
    end
endmodule
`default_nettype wire
